/* hdl/cpu_incr_branch_ops.sv */
// Purpose: executes increment, increment-skip-if-zero and absolute branch in quarter phases
// Assumes: ref_clk edge per quarter phase, AHB-Lite slave with zero wait states
// Notes: software loads an instruction word, this core runs it and updates state
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
module cpu_incr_branch_ops #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic busy,
    output logic [3:0] q_phase,
    output logic nop_cycle
);
    typedef struct packed {
        incr_branch_pkg::core_state_e state;
        logic [1:0] qtr;
        logic [1:0] nop_left;
        logic ext_en;
        logic [5:0] flags;
        logic illegal;
        logic [7:0] wreg;
        logic [ADDR_W-9:0] bank;
        logic [ADDR_W-1:0] index_base;
        logic [20:0] pc;
        logic [31:0] instr;
        logic [1:0] next_words;
        logic [ADDR_W-1:0] mem_addr;
        logic [ADDR_W-1:0] op_addr;
        logic [7:0] result;
        logic bus_pend;
        logic bus_wr;
        logic [7:0] bus_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [3:0] q_phase;
        logic nop_cycle;
        logic busy;
    } state_s;

    state_s q, d;
    logic [7:0] rd_data;
    logic [ADDR_W-1:0] rd_addr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic is_incr, is_skip, is_branch, to_file, idle, bus_write;
    logic [7:0] fld;

    file_ram #(.DATA_W(8), .ADDR_W(ADDR_W)) u_ram (
        .ref_clk(ref_clk),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // instruction decode from the held words
    assign is_incr = q.instr[15:10] == incr_branch_pkg::OP_INCR;
    assign is_skip = q.instr[15:10] == incr_branch_pkg::OP_INCR_SKIP;
    assign is_branch = (q.instr[15:8] == incr_branch_pkg::OP_BRANCH)
        && (q.instr[31:28] == incr_branch_pkg::OP_WORD2);
    assign to_file = q.instr[incr_branch_pkg::DEST_BIT];
    assign fld = q.instr[7:0];
    assign idle = q.state == incr_branch_pkg::CORE_IDLE;
    assign bus_write = q.bus_pend && q.bus_wr;

    // one shared ram: the core writes it while busy, the bus writes it only while idle
    assign rd_addr = (q.state == incr_branch_pkg::CORE_EXEC
        && q.qtr == incr_branch_pkg::QTR_READ) ? q.op_addr : q.mem_addr;
    assign wr_en = (q.state == incr_branch_pkg::CORE_EXEC
        && q.qtr == incr_branch_pkg::QTR_WRITE && (is_incr || is_skip) && to_file)
        || (idle && bus_write && q.bus_addr == incr_branch_pkg::OFF_MEM_DATA);
    assign wr_addr = idle ? q.mem_addr : q.op_addr;
    assign wr_data = idle ? hwdata[7:0] : q.result;

    // next-state logic for core, registers and bus slave
    always_comb begin
        d = q;
        d.hreadyout = 1'b1;
        // core sequencing, one quarter per edge
        case (q.state)
            incr_branch_pkg::CORE_IDLE: begin
                d.qtr = incr_branch_pkg::QTR_DECODE;
            end
            incr_branch_pkg::CORE_EXEC: begin
                d.qtr = q.qtr + 2'h1;
                case (q.qtr)
                    incr_branch_pkg::QTR_DECODE: begin
                        if (q.instr[incr_branch_pkg::ACCESS_BIT]) begin
                            d.op_addr = {q.bank, fld};
                        end else if (fld <= incr_branch_pkg::INDEXED_LIMIT) begin
                            if (q.ext_en) begin
                                d.op_addr = q.index_base + ADDR_W'(fld);
                            end else begin
                                d.op_addr = ADDR_W'(fld);
                            end
                        end else begin
                            d.op_addr = {{(ADDR_W-8){1'b1}}, fld};
                        end
                    end
                    incr_branch_pkg::QTR_PROCESS: begin
                        d.result = rd_data + 8'h01;
                    end
                    incr_branch_pkg::QTR_WRITE: begin
                        d.state = incr_branch_pkg::CORE_IDLE;
                        d.pc = q.pc + incr_branch_pkg::PC_STEP;
                        if (is_incr || is_skip) begin
                            if (!to_file) begin
                                d.wreg = q.result;
                            end
                        end
                        if (is_incr) begin
                            // carry out of +1 happens exactly when the result wraps to zero
                            d.flags[incr_branch_pkg::FLG_C] = q.result == 8'h00;
                            d.flags[incr_branch_pkg::FLG_DC] = q.result[3:0] == 4'h0;
                            d.flags[incr_branch_pkg::FLG_Z] = q.result == 8'h00;
                            d.flags[incr_branch_pkg::FLG_OV] = q.result == 8'h80;
                            d.flags[incr_branch_pkg::FLG_N] = q.result[7];
                        end else if (is_skip) begin
                            if (q.result == 8'h00) begin
                                // fetched follower is dropped and replaced by no-operation cycles, one per word
                                d.state = incr_branch_pkg::CORE_NOP;
                                d.nop_left = q.next_words;
                                d.pc = q.pc + incr_branch_pkg::PC_STEP
                                    + {18'h00000, q.next_words, 1'b0};
                            end
                        end else if (is_branch) begin
                            // both words consumed here, so word two never decodes alone
                            d.pc = {q.instr[27:16], q.instr[7:0], 1'b0};
                            d.state = incr_branch_pkg::CORE_NOP;
                            d.nop_left = incr_branch_pkg::BRANCH_NOP_CYCLES;
                        end else begin
                            d.illegal = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            incr_branch_pkg::CORE_NOP: begin
                d.qtr = q.qtr + 2'h1;
                if (q.qtr == incr_branch_pkg::QTR_WRITE) begin
                    d.nop_left = q.nop_left - 2'h1;
                    if (q.nop_left == 2'h1) begin
                        d.state = incr_branch_pkg::CORE_IDLE;
                    end
                end
            end
            default: begin
                d.state = incr_branch_pkg::CORE_IDLE;
            end
        endcase

        // bus data phase: writes land only while the core is idle
        if (bus_write && idle) begin
            case (q.bus_addr)
                incr_branch_pkg::OFF_CTRL: d.ext_en = hwdata[0];
                incr_branch_pkg::OFF_STATUS: begin
                    d.flags = hwdata[5:0];
                    d.illegal = hwdata[incr_branch_pkg::STAT_ILLEGAL];
                end
                incr_branch_pkg::OFF_WREG: d.wreg = hwdata[7:0];
                incr_branch_pkg::OFF_BANK: d.bank = hwdata[ADDR_W-9:0];
                incr_branch_pkg::OFF_INDEX_BASE: d.index_base = hwdata[ADDR_W-1:0];
                incr_branch_pkg::OFF_PC: d.pc = {hwdata[20:1], 1'b0};
                incr_branch_pkg::OFF_NEXT_WORDS: begin
                    if (hwdata[1:0] != 2'h0) begin
                        d.next_words = hwdata[1:0];
                    end
                end
                incr_branch_pkg::OFF_MEM_ADDR: d.mem_addr = hwdata[ADDR_W-1:0];
                incr_branch_pkg::OFF_INSTR: begin
                    d.instr = hwdata;
                    d.state = incr_branch_pkg::CORE_EXEC;
                    d.qtr = incr_branch_pkg::QTR_DECODE;
                end
                default: begin
                end
            endcase
        end

        // bus address phase: capture and prepare read data
        d.bus_pend = hsel && hready && (htrans == incr_branch_pkg::HTRANS_NONSEQ);
        if (hsel && hready) begin
            d.bus_wr = hwrite;
            d.bus_addr = haddr[7:0];
        end
        d.hrdata = 32'h00000000;
        if (d.bus_pend && !hwrite) begin
            case (haddr[7:0])
                incr_branch_pkg::OFF_CTRL: d.hrdata = {31'h00000000, q.ext_en};
                incr_branch_pkg::OFF_STATUS: begin
                    d.hrdata[5:0] = q.flags;
                    d.hrdata[incr_branch_pkg::STAT_BUSY] = !idle;
                    d.hrdata[incr_branch_pkg::STAT_ILLEGAL] = q.illegal;
                end
                incr_branch_pkg::OFF_WREG: d.hrdata = {24'h000000, q.wreg};
                incr_branch_pkg::OFF_BANK: d.hrdata = 32'(q.bank);
                incr_branch_pkg::OFF_INDEX_BASE: d.hrdata = 32'(q.index_base);
                incr_branch_pkg::OFF_PC: d.hrdata = {11'h000, q.pc};
                incr_branch_pkg::OFF_INSTR: d.hrdata = q.instr;
                incr_branch_pkg::OFF_NEXT_WORDS: d.hrdata = {30'h00000000, q.next_words};
                incr_branch_pkg::OFF_MEM_ADDR: d.hrdata = 32'(q.mem_addr);
                incr_branch_pkg::OFF_MEM_DATA: d.hrdata = {24'h000000, rd_data};
                default: d.hrdata = 32'h00000000;
            endcase
        end

        // status outputs follow the next state so they are registered
        d.q_phase = (d.state == incr_branch_pkg::CORE_IDLE) ? 4'h0 : (4'h1 << d.qtr);
        d.nop_cycle = d.state == incr_branch_pkg::CORE_NOP;
        d.busy = d.state != incr_branch_pkg::CORE_IDLE; // registered so the pin has no decode
        d.flags[incr_branch_pkg::FLG_W] = 1'b0; // spare flag bit, kept at zero
    end

    // single state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
            q.state <= incr_branch_pkg::CORE_IDLE;
            q.next_words <= incr_branch_pkg::NEXT_WORDS_RESET;
            q.hreadyout <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = q.hreadyout;
    assign hrdata = q.hrdata;
    assign hresp = 1'b0 & q.hreadyout; // always OKAY
    assign busy = q.busy;
    assign q_phase = q.q_phase;
    assign nop_cycle = q.nop_cycle;
endmodule

/* hdl/incr_branch_pkg.sv */
// Purpose: shared constants and types for the increment / branch execution slice
// Assumes: 32-bit AHB-Lite word registers, one quarter phase per ref_clk edge
// Notes: offsets are byte addresses on haddr[7:0]
package incr_branch_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_WREG = 8'h08;
    localparam logic [7:0] OFF_BANK = 8'h0c;
    localparam logic [7:0] OFF_INDEX_BASE = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h14;
    localparam logic [7:0] OFF_INSTR = 8'h18;
    localparam logic [7:0] OFF_NEXT_WORDS = 8'h1c;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h20;
    localparam logic [7:0] OFF_MEM_DATA = 8'h24;

    // status register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam int FLG_W = 5;
    localparam int STAT_BUSY = 8;
    localparam int STAT_ILLEGAL = 9;

    // instruction fields
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam logic [5:0] OP_INCR = 6'h0a;       // register_increment, 0010 10da
    localparam logic [5:0] OP_INCR_SKIP = 6'h0f;  // increment_skip_zero, 0011 11da
    localparam logic [7:0] OP_BRANCH = 8'hef;     // absolute_branch first word
    localparam logic [3:0] OP_WORD2 = 4'hf;       // marker of any second word
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;

    // quarter phases of one instruction cycle
    localparam logic [1:0] QTR_DECODE = 2'h0;
    localparam logic [1:0] QTR_READ = 2'h1;
    localparam logic [1:0] QTR_PROCESS = 2'h2;
    localparam logic [1:0] QTR_WRITE = 2'h3;

    localparam int PC_W = 21;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [1:0] NEXT_WORDS_RESET = 2'h1;
    localparam logic [1:0] BRANCH_NOP_CYCLES = 2'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        CORE_IDLE = 3'h1,
        CORE_EXEC = 3'h2,
        CORE_NOP = 3'h4
    } core_state_e;
endpackage

/* hdl/file_ram.sv */
// Purpose: file register store with one write port and a registered read port
// Assumes: read address presented in one cycle, data valid after the next edge
// Notes: contents are not reset; software initialises them over the bus
module file_ram #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // read first, registered; a same-cycle write is seen one cycle later
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* tb/cpu_incr_branch_ops_chk_asserts.sv */
// Purpose: port-level checks of quarter sequencing, bus answers and instruction timing
// Assumes: one ref_clk domain, srst synchronous active high
// Notes: sees only the top module's ports and is attached by bind at the foot
module cpu_incr_branch_ops_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic busy,
    input wire logic [3:0] q_phase,
    input wire logic nop_cycle
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // zero wait states and OKAY are part of the hand-over, so any deviation is a slip
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rdata_idle_zero: assert property (
        !(hsel && hready && htrans == incr_branch_pkg::HTRANS_NONSEQ && !hwrite)
        |=> hrdata == 32'h0) else $error("read data left standing");
    a_instr_launch: assert property (hsel && hready && hwrite && !busy
        && htrans == incr_branch_pkg::HTRANS_NONSEQ
        && haddr[7:0] == incr_branch_pkg::OFF_INSTR |=> ##1 $rose(busy))
        else $error("instruction write did not start execution");
    a_quarter_order: assert property (
        q_phase == 4'h1 |=> q_phase == 4'h2 ##1 q_phase == 4'h4 ##1 q_phase == 4'h8)
        else $error("quarter phases out of order");
    a_quarter_busy: assert property ($onehot0(q_phase) && busy == (q_phase != 4'h0))
        else $error("quarter phase does not match busy");
    a_start_decode: assert property ($rose(busy) |-> q_phase == 4'h1)
        else $error("instruction did not begin in decode quarter");
    a_busy_min_cycle: assert property ($rose(busy) |-> busy[*4])
        else $error("instruction shorter than one cycle");
    a_busy_bounded: assert property ($rose(busy) |-> ##[4:16] !busy)
        else $error("instruction ran past four cycles");
    a_end_on_write: assert property ($fell(busy) |-> $past(q_phase) == 4'h8)
        else $error("instruction ended mid cycle");
    a_nop_after_exec: assert property (
        $rose(nop_cycle) |-> q_phase == 4'h1 && $past(q_phase) == 4'h8)
        else $error("no-operation cycle not aligned to a cycle boundary");
    a_nop_inside_busy: assert property (nop_cycle |-> busy)
        else $error("no-operation flagged while idle");
endmodule

bind cpu_incr_branch_ops cpu_incr_branch_ops_chk #(.ADDR_W(ADDR_W)) u_chk (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .busy(busy), .q_phase(q_phase), .nop_cycle(nop_cycle));

/* tb/cpu_incr_branch_ops_tb.sv */
// Purpose: self-checking bench driving the core over its register bus
// Assumes: hreadyout looped back to hready, file space 12 bits
// Notes: random operands come from a fixed seed, corner values mixed in
module cpu_incr_branch_ops_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, busy, nop_cycle;
    logic [31:0] hrdata;
    logic [3:0] q_phase;
    int n_fail = 0;
    int check_count = 0;

    cpu_incr_branch_ops #(.ADDR_W(12)) dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .busy(busy), .q_phase(q_phase), .nop_cycle(nop_cycle));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // ready and read data are taken at the rising edge itself, before the slave's
    // own update of that edge lands
    task automatic wait_rdy(output logic [31:0] rd);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        rd = hrdata;
        if (n >= 20) begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        logic [31:0] junk;
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= incr_branch_pkg::HTRANS_NONSEQ;
        wait_rdy(junk);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        xfer(1'b1, a, d, junk);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(nm, e, v);
    endtask

    // each bus call leaves an idle cycle, which the memory data read needs
    task automatic poke(input logic [11:0] ea, input logic [7:0] x);
        wr(incr_branch_pkg::OFF_MEM_ADDR, {20'h0, ea});
        wr(incr_branch_pkg::OFF_MEM_DATA, {24'h0, x});
    endtask

    task automatic run(input logic [31:0] ins, output int cyc, output int nops);
        wr(incr_branch_pkg::OFF_INSTR, ins);
        #1;
        cyc = 0;
        nops = 0;
        while (busy === 1'b1 && cyc < 40) begin
            cyc++;
            if (nop_cycle === 1'b1) nops++;
            @(posedge ref_clk);
            #1;
        end
        if (cyc >= 40) begin
            n_fail++;
            end_sim();
        end
    endtask

    function automatic logic [11:0] eff(input logic a, input logic [7:0] f,
        input logic [3:0] bk, input logic ext, input logic [11:0] base);
        if (a) return {bk, f};
        if (ext && f <= 8'h5f) return base + {4'h0, f};
        if (f <= 8'h5f) return {4'h0, f};
        return {4'hf, f};
    endfunction

    // status image {n, ov, z, dc, c} after adding one
    function automatic logic [4:0] flg(input logic [7:0] x);
        logic [7:0] r;
        r = x + 8'h01;
        return {r[7], x == 8'h7f, r == 8'h00, x[3:0] == 4'hf, x == 8'hff};
    endfunction

    initial begin
        int cyc, nops, nw, tk;
        logic [7:0] x, r, f;
        logic [3:0] bk;
        logic [11:0] base, ea;
        logic [31:0] pc;
        logic [4:0] st;
        logic [19:0] k;
        logic d, a, ext;
        void'($urandom(32'h4a2473c2));
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        rdchk("status", incr_branch_pkg::OFF_STATUS, 32'h0);
        rdchk("next_words", incr_branch_pkg::OFF_NEXT_WORDS, 32'h1);
        rdchk("pc", incr_branch_pkg::OFF_PC, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        // register increment over all addressing modes and destinations
        for (int i = 0; i < 14; i++) begin
            x = (i == 0) ? 8'hff : (i == 1) ? 8'h7f : (i == 2) ? 8'h0f : 8'($urandom);
            {d, a, ext, bk, f} = 15'($urandom);
            if (i == 3) {a, ext, f} = {1'b0, 1'b1, 8'h3c}; // indexed literal offset corner
            if (i == 4) {a, f} = {1'b1, 8'h90}; // banked corner
            base = 12'($urandom);
            pc = {12'h0, 19'($urandom), 1'b0};
            ea = eff(a, f, bk, ext, base);
            r = x + 8'h01;
            wr(incr_branch_pkg::OFF_CTRL, {31'h0, ext});
            wr(incr_branch_pkg::OFF_BANK, {28'h0, bk});
            wr(incr_branch_pkg::OFF_INDEX_BASE, {20'h0, base});
            wr(incr_branch_pkg::OFF_PC, pc);
            wr(incr_branch_pkg::OFF_WREG, 32'h0);
            poke(ea, x);
            run({16'h0, incr_branch_pkg::OP_INCR, d, a, f}, cyc, nops);
            chk("incr cycles", 32'd4, cyc);
            rdchk("incr flags", incr_branch_pkg::OFF_STATUS, {27'h0, flg(x)});
            rdchk("incr pc", incr_branch_pkg::OFF_PC, pc + 32'h2);
            rdchk("wreg", incr_branch_pkg::OFF_WREG, {24'h0, d ? 8'h00 : r});
            wr(incr_branch_pkg::OFF_MEM_ADDR, {20'h0, ea});
            rdchk("file", incr_branch_pkg::OFF_MEM_DATA, {24'h0, d ? r : x});
        end
        $display("test increment done");
        // skip over one, two and three word followers, taken and not taken
        wr(incr_branch_pkg::OFF_CTRL, 32'h0);
        for (nw = 1; nw <= 3; nw++) begin
            for (tk = 0; tk < 2; tk++) begin
                st = 5'($urandom);
                pc = {12'h0, 19'($urandom), 1'b0};
                x = tk ? 8'hff : 8'($urandom % 255);
                wr(incr_branch_pkg::OFF_NEXT_WORDS, nw);
                wr(incr_branch_pkg::OFF_STATUS, {27'h0, st});
                wr(incr_branch_pkg::OFF_PC, pc);
                poke(12'h020, x);
                run({16'h0, incr_branch_pkg::OP_INCR_SKIP, 2'b10, 8'h20}, cyc, nops);
                chk("skip cycles", tk ? 4 + 4 * nw : 4, cyc);
                chk("skip nops", tk ? 4 * nw : 0, nops);
                rdchk("skip flags", incr_branch_pkg::OFF_STATUS, {27'h0, st});
                rdchk("skip pc", incr_branch_pkg::OFF_PC, pc + 2 + (tk ? 2 * nw : 0));
                wr(incr_branch_pkg::OFF_MEM_ADDR, 32'h20);
                rdchk("skip file", incr_branch_pkg::OFF_MEM_DATA, {24'h0, x + 8'h01});
            end
        end
        $display("test skip done");
        // absolute branch, top literal first
        for (int j = 0; j < 3; j++) begin
            k = (j == 0) ? 20'hfffff : 20'($urandom);
            st = 5'($urandom);
            wr(incr_branch_pkg::OFF_STATUS, {27'h0, st});
            run({incr_branch_pkg::OP_WORD2, k[19:8], incr_branch_pkg::OP_BRANCH, k[7:0]},
                cyc, nops);
            chk("branch cycles", 32'd8, cyc);
            chk("branch nops", 32'd4, nops);
            rdchk("branch pc", incr_branch_pkg::OFF_PC, {11'h0, k, 1'b0});
            rdchk("branch flags", incr_branch_pkg::OFF_STATUS, {27'h0, st});
        end
        $display("test branch done");
        // an unknown word runs one plain cycle and raises the illegal flag
        wr(incr_branch_pkg::OFF_STATUS, 32'h00000000);
        wr(incr_branch_pkg::OFF_PC, 32'h00000100);
        run(32'h00000000, cyc, nops);
        chk("illegal cycles", 32'h4, cyc);
        rdchk("illegal status", incr_branch_pkg::OFF_STATUS, 32'h00000200);
        rdchk("illegal pc", incr_branch_pkg::OFF_PC, 32'h00000102);
        $display("test illegal done");
        end_sim();
    end
endmodule
